// File: wdmr_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Watchdog and manual reset supervisor.
// Behaviour
// - Manual reset low for the push-button delay makes both outputs active.
// - After manual reset rises, outputs stay active at least 250 msec.
// - Debouncer rejects lows under 1 msec, accepts lows of 20 msec.
// - No strobe edge within the timeout forces both outputs active.
// - Timeout is 150, 600 or 1200 msec for select low, open, high.
// - A fresh timeout starts as soon as both outputs go inactive.
// - A falling strobe edge before expiry restarts the full timeout.
// - On watchdog expiry outputs go active for at least 250 msec.
// - Only falling strobe edges restart the watchdog.
// - Each timeout lies within its guaranteed range for its setting.
module wdmr_top
#(
  parameter int unsigned PBD_CYCLES = wdmr_pkg::PBD_CYC,
  parameter int unsigned HOLD_CYCLES = wdmr_pkg::RESET_HOLD_CYC,
  parameter int unsigned TO_LOW_CYCLES = wdmr_pkg::WD_LOW_CYC,
  parameter int unsigned TO_OPEN_CYCLES = wdmr_pkg::WD_OPEN_CYC,
  parameter int unsigned TO_HIGH_CYCLES = wdmr_pkg::WD_HIGH_CYC
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Manual reset pin, low to request a reset.
  input wire logic manualResetN,
  // Watchdog strobe pin, falling edges restart the watchdog.
  input wire logic watchdogStrobeN,
  // Three-level timeout select: 0 low, 1 open, 2 high.
  input wire logic [1:0] timeoutSelect,
  // Complementary reset outputs toward the processor.
  output logic resetOut,
  output logic resetOutN
);
  import wdmr_pkg::*;

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

  // ============================================================
  // Elaboration checks on the counts.
  generate
    if (PBD_CYCLES < 1 || HOLD_CYCLES < 1)
    begin : g_bad_short
      $error("Debounce and hold counts must be at least one cycle.");
    end
    if (PBD_CYCLES > PB_RECOG_CYC)
    begin : g_bad_pbd
      $error("Debounce delay exceeds the guaranteed recognition time.");
    end
    // Timeouts must be ordered and within their longest bounds.
    if (TO_LOW_CYCLES < 1 || TO_LOW_CYCLES > TO_OPEN_CYCLES ||
        TO_OPEN_CYCLES > TO_HIGH_CYCLES)
    begin : g_bad_order
      $error("Watchdog timeouts must be nonzero and ordered.");
    end
    if (TO_LOW_CYCLES > WD_LOW_MAX_CYC ||
        TO_OPEN_CYCLES > WD_OPEN_MAX_CYC ||
        TO_HIGH_CYCLES > WD_HIGH_MAX_CYC)
    begin : g_bad_max
      $error("Watchdog timeout exceeds its guaranteed maximum.");
    end
  endgenerate

  // Maps a select level to the last count of its timeout.
  function automatic logic [CNT_W-1:0] selToLast(input logic [1:0] sel);
    logic [CNT_W-1:0] res;
    res = CNT_W'(TO_HIGH_CYCLES - 1);
    case (sel)
      SEL_LOW: res = CNT_W'(TO_LOW_CYCLES - 1);
      SEL_OPEN: res = CNT_W'(TO_OPEN_CYCLES - 1);
      SEL_HIGH: res = CNT_W'(TO_HIGH_CYCLES - 1);
      default: res = CNT_W'(TO_HIGH_CYCLES - 1);
    endcase
    return res;
  endfunction

  // ============================================================
  // Pin synchronisers, two flip-flops on every asynchronous input.
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] syncA_r;
  logic [PIN_W-1:0] syncA_nxt;
  logic [PIN_W-1:0] syncB_r;
  logic [PIN_W-1:0] syncB_nxt;

  assign pinRaw = {timeoutSelect, watchdogStrobeN, manualResetN};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      // Next values of both stages of one bit.
      always_comb
      begin
        syncA_nxt[gi] = pinRaw[gi];
        syncB_nxt[gi] = syncA_r[gi];
      end

      // Stages idle high, the released level of the manual reset and strobe pins.
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          syncA_r[gi] <= 1'b1;
          syncB_r[gi] <= 1'b1;
        end
        else
        begin
          syncA_r[gi] <= syncA_nxt[gi];
          syncB_r[gi] <= syncB_nxt[gi];
        end
      end
    end
  endgenerate

  // ============================================================
  // Manual reset debouncing.
  logic pbActive;

  wdmr_debounce
  #(
    .DELAY_CYC(PBD_CYCLES)
  )
  u_debounce
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .levelN(syncB_r[PIN_MRST]),
    .pressed(pbActive)
  );

  // ============================================================
  // Strobe falling-edge detection.
  logic strbPrev_r;
  logic strbPrev_nxt;
  logic strobeFall;

  // Only a high-to-low change counts; levels and rises are ignored.
  assign strobeFall = strbPrev_r & ~syncB_r[PIN_STRB];

  // Next value of the previous strobe level.
  always_comb
  begin
    strbPrev_nxt = syncB_r[PIN_STRB];
  end

  // Previous strobe level.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      strbPrev_r <= 1'b1;
    else
      strbPrev_r <= strbPrev_nxt;
  end

  // ============================================================
  // Supervisor state machine, hold timer and watchdog timer.
  wdmr_state_t state_r;
  wdmr_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] toLast_r;
  logic [CNT_W-1:0] toLast_nxt;
  logic rstActive_r;
  logic rstActive_nxt;

  // Next state, shared counter and latched timeout.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    toLast_nxt = toLast_r;
    case (state_r)
      WDMR_RUN:
      begin
        if (pbActive)
        begin
          state_nxt = WDMR_PUSH;
          cnt_nxt = '0;
        end
        else if (strobeFall)
          cnt_nxt = '0;
        else if (cnt_r >= toLast_r)
        begin
          state_nxt = WDMR_HOLD;
          cnt_nxt = '0;
        end
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      WDMR_PUSH:
      begin
        cnt_nxt = '0;
        if (!pbActive)
          state_nxt = WDMR_HOLD;
      end
      WDMR_HOLD:
      begin
        // Select is sampled only while reset stands.
        toLast_nxt = selToLast(syncB_r[PIN_SEL1:PIN_SEL0]);
        if (pbActive)
        begin
          state_nxt = WDMR_PUSH;
          cnt_nxt = '0;
        end
        else if (cnt_r == HOLD_LAST)
        begin
          state_nxt = WDMR_RUN;
          cnt_nxt = '0;
        end
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      default:
      begin
        state_nxt = WDMR_HOLD;
        cnt_nxt = '0;
      end
    endcase
    rstActive_nxt = (state_nxt != WDMR_RUN);
  end

  // Registers; reset starts a full hold with outputs active.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= WDMR_HOLD;
      cnt_r <= '0;
      toLast_r <= CNT_W'(TO_HIGH_CYCLES - 1);
      rstActive_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      toLast_r <= toLast_nxt;
      rstActive_r <= rstActive_nxt;
    end
  end

  // Complementary outputs from one flip-flop.
  assign resetOut = rstActive_r;
  assign resetOutN = ~rstActive_r;

  // ============================================================
  // Checks on the supervisor.

  property p_push_active;
    @(posedge clk_sys) disable iff (!nrst)
    pbActive |=> rstActive_r && state_r == WDMR_PUSH;
  endproperty
  a_push_active: assert property (p_push_active)
    else $error("Manual reset did not drive the outputs active.");

  property p_push_release_hold;
    @(posedge clk_sys) disable iff (!nrst)
    state_r == WDMR_PUSH && !pbActive |=>
      state_r == WDMR_HOLD && cnt_r == '0 && rstActive_r;
  endproperty
  a_push_release_hold: assert property (p_push_release_hold)
    else $error("Release of manual reset did not start a full hold.");

  property p_expiry_reset;
    @(posedge clk_sys) disable iff (!nrst)
    state_r == WDMR_RUN && cnt_r >= toLast_r && !strobeFall && !pbActive
      |=> state_r == WDMR_HOLD && cnt_r == '0 && resetOut && !resetOutN;
  endproperty
  a_expiry_reset: assert property (p_expiry_reset)
    else $error("Watchdog expiry did not force a reset.");

  property p_select_decode;
    @(posedge clk_sys) disable iff (!nrst)
    state_r == WDMR_HOLD |=>
      toLast_r == selToLast($past(syncB_r[PIN_SEL1:PIN_SEL0]));
  endproperty
  a_select_decode: assert property (p_select_decode)
    else $error("Timeout does not match the select level.");

  property p_select_stable;
    @(posedge clk_sys) disable iff (!nrst)
    state_r == WDMR_RUN && $past(state_r == WDMR_RUN) |-> $stable(toLast_r);
  endproperty
  a_select_stable: assert property (p_select_stable)
    else $error("Timeout changed while the watchdog was running.");

  property p_fresh_start;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(rstActive_r) |-> state_r == WDMR_RUN && cnt_r == '0 &&
      $past(state_r == WDMR_HOLD) && $past(cnt_r) == HOLD_LAST;
  endproperty
  a_fresh_start: assert property (p_fresh_start)
    else $error("Watchdog did not start fresh on reset release.");

  property p_strobe_restart;
    @(posedge clk_sys) disable iff (!nrst)
    state_r == WDMR_RUN && strobeFall && !pbActive |=>
      state_r == WDMR_RUN && cnt_r == '0 && !rstActive_r;
  endproperty
  a_strobe_restart: assert property (p_strobe_restart)
    else $error("Strobe edge did not restart the watchdog.");

  property p_hold_kept;
    @(posedge clk_sys) disable iff (!nrst)
    state_r == WDMR_HOLD && cnt_r != HOLD_LAST && !pbActive |=>
      state_r == WDMR_HOLD && cnt_r == $past(cnt_r) + 1'b1 && rstActive_r;
  endproperty
  a_hold_kept: assert property (p_hold_kept)
    else $error("Reset hold was cut short.");

  property p_no_edge_counts;
    @(posedge clk_sys) disable iff (!nrst)
    state_r == WDMR_RUN && !strobeFall && !pbActive && cnt_r < toLast_r
      |=> cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_no_edge_counts: assert property (p_no_edge_counts)
    else $error("Watchdog restarted without a falling strobe edge.");

endmodule
`default_nettype wire

// File: wdmr_pkg.sv
`default_nettype none
// ============================================================
// Shared constants for the watchdog and manual reset supervisor.
package wdmr_pkg;

  // System clock rate in kHz, so that msec times multiply directly.
  localparam int CLK_FREQ_KHZ = 250000;

  // Counter width; the longest default count is 300,000,000 cycles.
  localparam int CNT_W = 32;

  // Push-button delay, rejection and recognition times in msec.
  localparam int PBD_TIME_MS = 4;
  localparam int PB_REJECT_MS = 1;
  localparam int PB_RECOG_MS = 20;

  // Minimum time the reset outputs stay active, in msec.
  localparam int RESET_HOLD_MS = 250;

  // Typical watchdog timeouts for the three select levels, in msec.
  localparam int WD_LOW_MS = 150;
  localparam int WD_OPEN_MS = 600;
  localparam int WD_HIGH_MS = 1200;

  // Longest guaranteed watchdog timeouts, in msec.
  localparam int WD_LOW_MAX_MS = 250;
  localparam int WD_OPEN_MAX_MS = 1000;
  localparam int WD_HIGH_MAX_MS = 2000;

  // Cycle counts derived from the times above.
  localparam int PBD_CYC = PBD_TIME_MS * CLK_FREQ_KHZ;
  localparam int PB_REJECT_CYC = PB_REJECT_MS * CLK_FREQ_KHZ;
  localparam int PB_RECOG_CYC = PB_RECOG_MS * CLK_FREQ_KHZ;
  localparam int RESET_HOLD_CYC = RESET_HOLD_MS * CLK_FREQ_KHZ;
  localparam int WD_LOW_CYC = WD_LOW_MS * CLK_FREQ_KHZ;
  localparam int WD_OPEN_CYC = WD_OPEN_MS * CLK_FREQ_KHZ;
  localparam int WD_HIGH_CYC = WD_HIGH_MS * CLK_FREQ_KHZ;
  localparam int WD_LOW_MAX_CYC = WD_LOW_MAX_MS * CLK_FREQ_KHZ;
  localparam int WD_OPEN_MAX_CYC = WD_OPEN_MAX_MS * CLK_FREQ_KHZ;
  localparam int WD_HIGH_MAX_CYC = WD_HIGH_MAX_MS * CLK_FREQ_KHZ;

  // Encoding of the three-level timeout select pin.
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;

  // Number of pin input bits that pass the synchroniser.
  localparam int PIN_W = 4;
  localparam int PIN_MRST = 0;
  localparam int PIN_STRB = 1;
  localparam int PIN_SEL0 = 2;
  localparam int PIN_SEL1 = 3;

  // Supervisor states.
  typedef enum logic [2:0]
  {
    WDMR_RUN = 3'h1,
    WDMR_PUSH = 3'h2,
    WDMR_HOLD = 3'h4
  } wdmr_state_t;

endpackage
`default_nettype wire

// File: wdmr_debounce.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Debouncer for the active-low manual reset input.
module wdmr_debounce
#(
  parameter int unsigned DELAY_CYC = wdmr_pkg::PBD_CYC
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Synchronised input level, low while pressed.
  input wire logic levelN,
  // Debounced press, high while the request stands.
  output logic pressed
);
  import wdmr_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY_CYC - 1);

  logic [CNT_W-1:0] lowCnt_r;
  logic [CNT_W-1:0] lowCnt_nxt;
  logic pressed_r;
  logic pressed_nxt;

  // ============================================================
  // Low-time counter: a press counts only after a full delay low.
  always_comb
  begin
    lowCnt_nxt = '0;
    pressed_nxt = 1'b0;
    if (!levelN)
    begin
      pressed_nxt = pressed_r;
      lowCnt_nxt = lowCnt_r;
      if (lowCnt_r == LAST)
        pressed_nxt = 1'b1;
      else
        lowCnt_nxt = lowCnt_r + 1'b1;
    end
  end

  // Registers of the debouncer.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      lowCnt_r <= '0;
      pressed_r <= 1'b0;
    end
    else
    begin
      lowCnt_r <= lowCnt_nxt;
      pressed_r <= pressed_nxt;
    end
  end

  assign pressed = pressed_r;

  // A press is recognised only after exactly the full low count.
  property p_press_after_delay;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(pressed_r) |-> $past(lowCnt_r) == LAST && $past(!levelN);
  endproperty
  a_press_after_delay: assert property (p_press_after_delay)
    else $error("Press recognised before the debounce delay.");

  // A high input drops the press and the count at once.
  property p_release_clears;
    @(posedge clk_sys) disable iff (!nrst)
    levelN |=> !pressed_r && lowCnt_r == '0;
  endproperty
  a_release_clears: assert property (p_release_clears)
    else $error("Press or count survived a high input.");

endmodule
`default_nettype wire

// File: wdmr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host processor model that strobes the watchdog pin.
module wdmr_host_model
(
  // Clock.
  input wire logic clk_sys,
  // Strobe control from the bench.
  input wire logic strobeEn,
  input wire logic [15:0] strobePeriod,
  input wire logic idleLevel,
  // Strobe pin toward the supervisor.
  output logic watchdogStrobeN
);
  int unsigned phase;

  // One falling edge per period; each level lasts several cycles.
  initial
  begin
    watchdogStrobeN = 1'b1;
    phase = 0;
    forever
    begin
      @(negedge clk_sys);
      if (strobeEn)
      begin
        phase = (phase + 1 >= strobePeriod) ? 0 : phase + 1;
        watchdogStrobeN <= (phase >= 3);
      end
      else
      begin
        phase = 0;
        watchdogStrobeN <= idleLevel;
      end
    end
  end
endmodule
`default_nettype wire

// File: wdmr_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the watchdog and manual reset block.
module wdmr_top_tb_top;
  localparam int PBD = 8;
  localparam int HOLD = 20;
  localparam int TLOW = 30;
  localparam int TOPEN = 60;
  localparam int THIGH = 90;

  logic clk_sys;
  logic nrst;
  logic manualResetN;
  logic watchdogStrobeN;
  logic [1:0] timeoutSelect;
  logic resetOut;
  logic resetOutN;
  logic strobeEn;
  logic [15:0] strobePeriod;
  logic idleLevel;
  int errors;
  int samplesChecked;

  // Design with shortened counts.
  wdmr_top #(.PBD_CYCLES(PBD), .HOLD_CYCLES(HOLD), .TO_LOW_CYCLES(TLOW),
    .TO_OPEN_CYCLES(TOPEN), .TO_HIGH_CYCLES(THIGH)) u_wdmr_top (
    .clk_sys(clk_sys), .nrst(nrst), .manualResetN(manualResetN),
    .watchdogStrobeN(watchdogStrobeN), .timeoutSelect(timeoutSelect),
    .resetOut(resetOut), .resetOutN(resetOutN));

  // Host processor on the strobe pin.
  wdmr_host_model u_wdmr_host_model (.clk_sys(clk_sys),
    .strobeEn(strobeEn), .strobePeriod(strobePeriod),
    .idleLevel(idleLevel), .watchdogStrobeN(watchdogStrobeN));

  // 250 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ============================================================
  // Shared tasks.
  task automatic cmp_bit(input string what, input logic exp,
    input logic seen);
    samplesChecked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %0b seen %0b", what, exp, seen);
    end
  endtask

  task automatic cmp_range(input string what, input int lo, input int hi,
    input int seen);
    samplesChecked++;
    if (seen < lo || seen > hi)
    begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask

  // Counts cycles until the reset output reaches a level, bounded.
  task automatic wait_out(input logic val, input int limit, output int n);
    n = 0;
    while (resetOut !== val && n < limit)
    begin
      @(negedge clk_sys);
      n++;
    end
    cmp_bit("resetOut", val, resetOut);
    cmp_bit("resetOutN", ~val, resetOutN);
  endtask

  // Counts cycles with the reset output active over a span.
  task automatic count_high(input int cycles, output int k);
    k = 0;
    repeat (cycles)
    begin
      @(negedge clk_sys);
      cmp_bit("complement", 1'b1, resetOut ^ resetOutN);
      if (resetOut !== 1'b0)
        k++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ============================================================
  // Scenarios.
  // Timeout for one select level; select is changed as the run starts.
  task automatic t_timeout(input logic [1:0] sel, input int to);
    int n;
    wait_out(1'b1, 400, n);
    timeoutSelect <= sel;
    wait_out(1'b0, HOLD + 10, n);
    cmp_range("entry hold", HOLD - 1, HOLD + 1, n);
    timeoutSelect <= (sel == 2'h2) ? 2'h0 : 2'h2;
    wait_out(1'b1, to + 10, n);
    cmp_range("timeout", to - 1, to + 1, n);
    timeoutSelect <= sel;
    wait_out(1'b0, HOLD + 10, n);
    cmp_range("hold", HOLD - 1, HOLD + 1, n);
    $display("test timeout sel %0d finished", sel);
  endtask

  // Regular strobes keep the outputs inactive, then stop.
  task automatic t_keepalive;
    int n;
    int k;
    wait_out(1'b1, 400, n);
    timeoutSelect <= 2'h0;
    strobePeriod <= 16'h000c;
    strobeEn <= 1'b1;
    wait_out(1'b0, HOLD + 10, n);
    count_high(4 * TLOW, k);
    cmp_range("keepalive", 0, 0, k);
    strobeEn <= 1'b0;
    wait_out(1'b1, TLOW + 10, n);
    cmp_range("stop", TLOW - 12, TLOW + 4, n);
    $display("test keepalive finished");
  endtask

  // A single falling edge near expiry restarts the full period.
  task automatic t_restart;
    int n;
    wait_out(1'b0, HOLD + 10, n);
    repeat (20) @(negedge clk_sys);
    idleLevel <= 1'b0;
    wait_out(1'b1, TLOW + 20, n);
    cmp_range("restart", TLOW, TLOW + 6, n);
    $display("test restart finished");
  endtask

  // A rising edge and a static low do not restart the watchdog.
  task automatic t_rising;
    int n;
    wait_out(1'b0, HOLD + 10, n);
    repeat (10) @(negedge clk_sys);
    idleLevel <= 1'b1;
    wait_out(1'b1, TLOW + 20, n);
    cmp_range("rising", TLOW - 11, TLOW - 9, n);
    $display("test rising finished");
  endtask

  // Short press rejected, long press resets and holds after release.
  task automatic t_manual;
    int n;
    int k;
    strobeEn <= 1'b1;
    wait_out(1'b0, HOLD + 10, n);
    manualResetN <= 1'b0;
    repeat (PBD - 3) @(negedge clk_sys);
    manualResetN <= 1'b1;
    count_high(PBD + 6, k);
    cmp_range("short press", 0, 0, k);
    manualResetN <= 1'b0;
    wait_out(1'b1, PBD + 10, n);
    cmp_range("press delay", PBD + 1, PBD + 4, n);
    count_high(30, k);
    cmp_range("pressed", 30, 30, k);
    manualResetN <= 1'b1;
    wait_out(1'b0, HOLD + 20, n);
    cmp_range("release hold", HOLD, HOLD + 6, n);
    $display("test manual finished");
  endtask

  // ============================================================
  // Main sequence.
  initial
  begin
    errors = 0;
    samplesChecked = 0;
    nrst = 1'b0;
    manualResetN = 1'b1;
    timeoutSelect = 2'h0;
    strobeEn = 1'b0;
    strobePeriod = 16'h000c;
    idleLevel = 1'b1;
    repeat (10) @(negedge clk_sys);
    nrst <= 1'b1;
    t_timeout(2'h0, TLOW);
    t_timeout(2'h1, TOPEN);
    t_timeout(2'h2, THIGH);
    t_keepalive;
    t_restart;
    t_rising;
    t_manual;
    test_done;
  end

  // Watchdog on the run; all tests need about 900 cycles.
  initial
  begin
    #100000;
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
